/* core/rcac_pkg.sv */
package rcac_pkg;
  // register addresses on the host bus
  localparam logic [5:0] BIT_SYNC_LOOP_CONFIG_ADDR = 6'h1A;
  localparam logic [5:0] AGC_GAIN_LIMITS_AND_TARGET_ADDR = 6'h1B;
  // reset values
  localparam logic [7:0] BIT_SYNC_LOOP_CONFIG_RST = 8'h6C;
  localparam logic [7:0] AGC_GAIN_LIMITS_AND_TARGET_RST = 8'h03;
  // bit sync field positions
  localparam int CLKREC_INT_GAIN_PRE_LSB = 6;
  localparam int CLKREC_PROP_GAIN_PRE_LSB = 4;
  localparam int CLKREC_INT_GAIN_POST_SEL_BIT = 3;
  localparam int CLKREC_PROP_GAIN_POST_SEL_BIT = 2;
  localparam int RATE_OFFSET_SATURATION_LSB = 0;
  // agc field positions
  localparam int VGA_GAIN_CEILING_LSB = 6;
  localparam int LNA_GAIN_CEILING_LSB = 3;
  localparam int FILTER_AMPLITUDE_TARGET_LSB = 0;
  // gains are in units of base/2 so halving stays exact
  localparam int GAIN_W = 4;
  // digital vga step count, width of step index
  localparam int VGA_STEP_W = 3;
  localparam logic [VGA_STEP_W-1:0] VGA_TOP_STEP = 3'h7;
  // rate offset limit in 1/1000 percent
  localparam logic [15:0] RATE_LIM_0 = 16'h0000;
  localparam logic [15:0] RATE_LIM_1 = 16'h0C35; // 3.125 %
  localparam logic [15:0] RATE_LIM_2 = 16'h186A; // 6.25 %
  localparam logic [15:0] RATE_LIM_3 = 16'h30D4; // 12.5 %
  // lna cap below maximum, in tenths of a dB
  localparam logic [7:0] LNA_CAP_0 = 8'h00;
  localparam logic [7:0] LNA_CAP_1 = 8'h1A;
  localparam logic [7:0] LNA_CAP_2 = 8'h3D;
  localparam logic [7:0] LNA_CAP_3 = 8'h4A;
  localparam logic [7:0] LNA_CAP_4 = 8'h5C;
  localparam logic [7:0] LNA_CAP_5 = 8'h73;
  localparam logic [7:0] LNA_CAP_6 = 8'h92;
  localparam logic [7:0] LNA_CAP_7 = 8'hAB;
  // amplitude target in dB
  localparam logic [5:0] TGT_0 = 6'h18;
  localparam logic [5:0] TGT_1 = 6'h1B;
  localparam logic [5:0] TGT_2 = 6'h1E;
  localparam logic [5:0] TGT_3 = 6'h21;
  localparam logic [5:0] TGT_4 = 6'h24;
  localparam logic [5:0] TGT_5 = 6'h26;
  localparam logic [5:0] TGT_6 = 6'h28;
  localparam logic [5:0] TGT_7 = 6'h2A;

  // loop phase
  typedef enum logic {RCAC_PRE_SYNC, RCAC_POST_SYNC} rcac_phase_t;

  // register write request from the spi engine
  typedef struct packed {
    logic we;
    logic [5:0] addr;
    logic [7:0] wdata;
  } rcac_wr_t;

  // settings handed to the demodulator and agc
  typedef struct packed {
    logic [GAIN_W-1:0] int_gain;
    logic [GAIN_W-1:0] prop_gain;
    logic loops_frozen;
    logic [15:0] rate_offset_limit;
    logic [VGA_STEP_W-1:0] vga_max_step;
    logic [7:0] lna_cap_below_max;
    logic [5:0] amp_target_db;
  } rcac_cfg_t;

  // whole state of the block
  typedef struct packed {
    logic [7:0] bit_sync_loop_config;
    logic [7:0] agc_gain_limits_and_target;
    rcac_phase_t phase;
    logic carrier_seen;
    rcac_cfg_t cfg;
  } rcac_state_t;
endpackage

/* core/rcac_config.sv */
`timescale 1ns/1ps
// Contract
// - post-sync integral gain: same, or halved
// - post-sync proportional gain: same, or base
// - switch gains to post-sync at sync detect
// - rate offset limit codes 0..3 clamp values
// - vga ceiling removes top N gain steps
// - lna ceiling caps combined lna gain
// - amplitude target codes map 24..42 dB
// - pre-sync gains are base times code+1
// - gating freezes loops until carrier sense
module rcac_config (
  input wire logic clk,
  input wire logic srst,
  // register write from the spi engine
  input wire rcac_pkg::rcac_wr_t wr,
  // register read address
  input wire logic [5:0] rd_addr,
  output logic [7:0] rd_data,
  // loop freeze enable bit lives in the frequency offset register
  input wire logic loop_freeze_until_carrier,
  // pulse from the packet engine on sync word detect
  input wire logic sync_detected,
  // receiver back to idle or new packet search
  input wire logic sync_search_restart,
  // carrier sense level from the rssi logic, same clock
  input wire logic carrier_sense,
  output rcac_pkg::rcac_cfg_t cfg
);
  rcac_pkg::rcac_state_t st;
  rcac_pkg::rcac_state_t next_st;

  // field views of the live registers
  logic [1:0] pre_ki;
  logic [1:0] pre_kp;
  logic post_ki;
  logic post_kp;
  assign pre_ki = st.bit_sync_loop_config[rcac_pkg::CLKREC_INT_GAIN_PRE_LSB +: 2];
  assign pre_kp = st.bit_sync_loop_config[rcac_pkg::CLKREC_PROP_GAIN_PRE_LSB +: 2];
  assign post_ki = st.bit_sync_loop_config[rcac_pkg::CLKREC_INT_GAIN_POST_SEL_BIT];
  assign post_kp = st.bit_sync_loop_config[rcac_pkg::CLKREC_PROP_GAIN_POST_SEL_BIT];

  // pre-sync gain in half-base units: 2*(code+1)
  function automatic logic [rcac_pkg::GAIN_W-1:0] pre_gain(input logic [1:0] code);
    pre_gain = {1'b0, code, 1'b0} + 4'h2;
  endfunction

  // next-state logic
  always_comb begin
    next_st = st;
    // register writes; sync restart has no effect on the registers
    if (wr.we && wr.addr == rcac_pkg::BIT_SYNC_LOOP_CONFIG_ADDR) begin
      next_st.bit_sync_loop_config = wr.wdata;
    end
    if (wr.we && wr.addr == rcac_pkg::AGC_GAIN_LIMITS_AND_TARGET_ADDR) begin
      next_st.agc_gain_limits_and_target = wr.wdata;
    end
    // phase: detect wins over restart so a sync event is never lost
    if (sync_detected) begin
      next_st.phase = rcac_pkg::RCAC_POST_SYNC;
    end else if (sync_search_restart) begin
      next_st.phase = rcac_pkg::RCAC_PRE_SYNC;
    end
    // carrier seen latch releases the freeze; rearmed on restart
    if (carrier_sense) begin
      next_st.carrier_seen = 1'b1;
    end else if (sync_search_restart) begin
      next_st.carrier_seen = 1'b0;
    end
    // gains from the registered state, two cycles after the detect or restart pulse
    case (st.phase)
      rcac_pkg::RCAC_POST_SYNC: begin
        next_st.cfg.int_gain = post_ki ? (pre_gain(pre_ki) >> 1) : pre_gain(pre_ki);
        next_st.cfg.prop_gain = post_kp ? 4'h2 : pre_gain(pre_kp);
      end
      default: begin
        next_st.cfg.int_gain = pre_gain(pre_ki);
        next_st.cfg.prop_gain = pre_gain(pre_kp);
      end
    endcase
    next_st.cfg.loops_frozen = loop_freeze_until_carrier && !st.carrier_seen && !carrier_sense;
    case (st.bit_sync_loop_config[rcac_pkg::RATE_OFFSET_SATURATION_LSB +: 2])
      2'h1: next_st.cfg.rate_offset_limit = rcac_pkg::RATE_LIM_1;
      2'h2: next_st.cfg.rate_offset_limit = rcac_pkg::RATE_LIM_2;
      2'h3: next_st.cfg.rate_offset_limit = rcac_pkg::RATE_LIM_3;
      default: next_st.cfg.rate_offset_limit = rcac_pkg::RATE_LIM_0;
    endcase
    // highest usable step is top step minus the excluded count
    next_st.cfg.vga_max_step = rcac_pkg::VGA_TOP_STEP -
      {1'b0, st.agc_gain_limits_and_target[rcac_pkg::VGA_GAIN_CEILING_LSB +: 2]};
    case (st.agc_gain_limits_and_target[rcac_pkg::LNA_GAIN_CEILING_LSB +: 3])
      3'h1: next_st.cfg.lna_cap_below_max = rcac_pkg::LNA_CAP_1;
      3'h2: next_st.cfg.lna_cap_below_max = rcac_pkg::LNA_CAP_2;
      3'h3: next_st.cfg.lna_cap_below_max = rcac_pkg::LNA_CAP_3;
      3'h4: next_st.cfg.lna_cap_below_max = rcac_pkg::LNA_CAP_4;
      3'h5: next_st.cfg.lna_cap_below_max = rcac_pkg::LNA_CAP_5;
      3'h6: next_st.cfg.lna_cap_below_max = rcac_pkg::LNA_CAP_6;
      3'h7: next_st.cfg.lna_cap_below_max = rcac_pkg::LNA_CAP_7;
      default: next_st.cfg.lna_cap_below_max = rcac_pkg::LNA_CAP_0;
    endcase
    case (st.agc_gain_limits_and_target[rcac_pkg::FILTER_AMPLITUDE_TARGET_LSB +: 3])
      3'h0: next_st.cfg.amp_target_db = rcac_pkg::TGT_0;
      3'h1: next_st.cfg.amp_target_db = rcac_pkg::TGT_1;
      3'h2: next_st.cfg.amp_target_db = rcac_pkg::TGT_2;
      3'h4: next_st.cfg.amp_target_db = rcac_pkg::TGT_4;
      3'h5: next_st.cfg.amp_target_db = rcac_pkg::TGT_5;
      3'h6: next_st.cfg.amp_target_db = rcac_pkg::TGT_6;
      3'h7: next_st.cfg.amp_target_db = rcac_pkg::TGT_7;
      default: next_st.cfg.amp_target_db = rcac_pkg::TGT_3;
    endcase
  end

  // state register; outputs settle one cycle after reset release
  always_ff @(posedge clk) begin
    if (srst) begin
      st.bit_sync_loop_config <= rcac_pkg::BIT_SYNC_LOOP_CONFIG_RST;
      st.agc_gain_limits_and_target <= rcac_pkg::AGC_GAIN_LIMITS_AND_TARGET_RST;
      st.phase <= rcac_pkg::RCAC_PRE_SYNC;
      st.carrier_seen <= 1'b0;
      // reset gains follow the reset field codes, so the two can never drift apart
      st.cfg.int_gain <= pre_gain(rcac_pkg::BIT_SYNC_LOOP_CONFIG_RST[rcac_pkg::CLKREC_INT_GAIN_PRE_LSB +: 2]);
      st.cfg.prop_gain <= pre_gain(rcac_pkg::BIT_SYNC_LOOP_CONFIG_RST[rcac_pkg::CLKREC_PROP_GAIN_PRE_LSB +: 2]);
      st.cfg.loops_frozen <= 1'b0;
      st.cfg.rate_offset_limit <= rcac_pkg::RATE_LIM_0;
      st.cfg.vga_max_step <= rcac_pkg::VGA_TOP_STEP;
      st.cfg.lna_cap_below_max <= rcac_pkg::LNA_CAP_0;
      st.cfg.amp_target_db <= rcac_pkg::TGT_3;
    end else begin
      st <= next_st;
    end
  end

  // read mux, unmapped addresses read zero; combinational by design
  always_comb begin
    case (rd_addr)
      rcac_pkg::BIT_SYNC_LOOP_CONFIG_ADDR: rd_data = st.bit_sync_loop_config;
      rcac_pkg::AGC_GAIN_LIMITS_AND_TARGET_ADDR: rd_data = st.agc_gain_limits_and_target;
      default: rd_data = 8'h00;
    endcase
  end

  // every setting leaves straight from the state flops
  assign cfg = st.cfg;

  // sync detect flips the phase and the gains follow one cycle later
  sequence s_sync_seen;
    sync_detected ##1 (st.phase == rcac_pkg::RCAC_POST_SYNC);
  endsequence
  property p_phase_switch;
    @(posedge clk) disable iff (srst) sync_detected |=> st.phase == rcac_pkg::RCAC_POST_SYNC;
  endproperty
  a_phase_switch: assert property (p_phase_switch) else $error("phase did not switch on sync");
  property p_int_post;
    @(posedge clk) disable iff (srst) s_sync_seen ##0 (post_ki && $stable(st.bit_sync_loop_config))
      |=> cfg.int_gain == ({1'b0, $past(pre_ki), 1'b0} + 4'h2) >> 1;
  endproperty
  a_int_post: assert property (p_int_post) else $error("post-sync integral gain wrong");
  property p_prop_post;
    @(posedge clk) disable iff (srst) (st.phase == rcac_pkg::RCAC_POST_SYNC && post_kp) |=> cfg.prop_gain == 4'h2;
  endproperty
  a_prop_post: assert property (p_prop_post) else $error("post-sync proportional gain wrong");
  property p_pre_gain;
    @(posedge clk) disable iff (srst) (st.phase == rcac_pkg::RCAC_PRE_SYNC)
      |=> cfg.prop_gain == {1'b0, $past(pre_kp), 1'b0} + 4'h2;
  endproperty
  a_pre_gain: assert property (p_pre_gain) else $error("pre-sync gain wrong");
  property p_rate_off;
    @(posedge clk) disable iff (srst) (st.bit_sync_loop_config[1:0] == 2'h0) |=> cfg.rate_offset_limit == 16'h0000;
  endproperty
  a_rate_off: assert property (p_rate_off) else $error("rate compensation not disabled");
  property p_vga;
    @(posedge clk) disable iff (srst) 1'b1
      |=> cfg.vga_max_step == 3'h7 - {1'b0, $past(st.agc_gain_limits_and_target[7:6])};
  endproperty
  a_vga: assert property (p_vga) else $error("vga ceiling wrong");
  property p_lna;
    @(posedge clk) disable iff (srst) (st.agc_gain_limits_and_target[5:3] == 3'h7) |=> cfg.lna_cap_below_max == 8'hAB;
  endproperty
  a_lna: assert property (p_lna) else $error("lna cap wrong");
  property p_tgt;
    @(posedge clk) disable iff (srst) (st.agc_gain_limits_and_target[2:0] == 3'h0) |=> cfg.amp_target_db == 6'h18;
  endproperty
  a_tgt: assert property (p_tgt) else $error("amplitude target wrong");
  property p_freeze;
    @(posedge clk) disable iff (srst) (loop_freeze_until_carrier && !st.carrier_seen && !carrier_sense)
      |=> cfg.loops_frozen;
  endproperty
  a_freeze: assert property (p_freeze) else $error("loops not frozen before carrier");
  // pre-sync integral gain scales with its own code
  property p_int_pre;
    @(posedge clk) disable iff (srst) (st.phase == rcac_pkg::RCAC_PRE_SYNC)
      |=> cfg.int_gain == {1'b0, $past(pre_ki), 1'b0} + 4'h2;
  endproperty
  a_int_pre: assert property (p_int_pre) else $error("pre-sync integral gain wrong");
  // post select clear keeps the integral gain of the acquisition phase
  property p_int_same;
    @(posedge clk) disable iff (srst) (st.phase == rcac_pkg::RCAC_POST_SYNC && !post_ki)
      |=> cfg.int_gain == {1'b0, $past(pre_ki), 1'b0} + 4'h2;
  endproperty
  a_int_same: assert property (p_int_same) else $error("post-sync integral gain not kept");
  // post select clear keeps the proportional gain of the acquisition phase
  property p_prop_same;
    @(posedge clk) disable iff (srst) (st.phase == rcac_pkg::RCAC_POST_SYNC && !post_kp)
      |=> cfg.prop_gain == {1'b0, $past(pre_kp), 1'b0} + 4'h2;
  endproperty
  a_prop_same: assert property (p_prop_same) else $error("post-sync proportional gain not kept");
  // a restart without detect returns the proportional gain to its acquisition value
  sequence s_restart_seen;
    (sync_search_restart && !sync_detected) ##1 (st.phase == rcac_pkg::RCAC_PRE_SYNC);
  endsequence
  property p_restart;
    @(posedge clk) disable iff (srst) s_restart_seen
      |=> cfg.prop_gain == {1'b0, $past(pre_kp), 1'b0} + 4'h2;
  endproperty
  a_restart: assert property (p_restart) else $error("gains did not return to pre-sync");
  // any carrier, now or latched, lets the loops run
  property p_release;
    @(posedge clk) disable iff (srst) (st.carrier_seen || carrier_sense) |=> !cfg.loops_frozen;
  endproperty
  a_release: assert property (p_release) else $error("loops still frozen after carrier");
  // widest limit code gives the widest clamp
  property p_rate_top;
    @(posedge clk) disable iff (srst) (st.bit_sync_loop_config[1:0] == 2'h3)
      |=> cfg.rate_offset_limit == rcac_pkg::RATE_LIM_3;
  endproperty
  a_rate_top: assert property (p_rate_top) else $error("rate limit clamp wrong");
endmodule // rcac_config

/* verification/rcac_host.sv */
`timescale 1ns/1ps
// host side: one byte per register, strobe high for one cycle
module rcac_host (
  input wire logic clk,
  output rcac_pkg::rcac_wr_t wr
);
  // idle bus from time zero
  initial wr = '0;
  // only called between packets, so gains never move mid-frame
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    wr <= '{we: 1'b1, addr: a, wdata: d};
    @(negedge clk);
    wr <= '0;
  endtask
endmodule // rcac_host

/* verification/rx_clock_recovery_agc_config_bench.sv */
`timescale 1ns/1ps
module rx_clock_recovery_agc_config_bench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [5:0] rd_addr = 6'h00;
  logic [7:0] rd_data;
  logic loop_freeze_until_carrier = 1'b0;
  logic sync_det = 1'b0;
  logic restart = 1'b0;
  logic carrier = 1'b0;
  rcac_pkg::rcac_wr_t wr;
  rcac_pkg::rcac_cfg_t cfg;
  int failures = 0;
  int checked = 0;
  // 8 ns period
  always #4 clk = ~clk;
  rcac_host u_host (.clk(clk), .wr(wr));
  rcac_config u_dut (.clk(clk), .srst(srst), .wr(wr), .rd_addr(rd_addr), .rd_data(rd_data),
    .loop_freeze_until_carrier(loop_freeze_until_carrier), .sync_detected(sync_det),
    .sync_search_restart(restart), .carrier_sense(carrier), .cfg(cfg));
  // single compare point
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // a write needs two edges to reach cfg
  task automatic settle();
    repeat (2) @(negedge clk);
  endtask
  // combinational read
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(negedge clk);
    rd_addr = a;
    #1 chk(rd_data, exp);
  endtask
  // one-cycle pulse on detect (0) or restart (1), then one edge for cfg to follow
  task automatic pulse(input logic is_restart);
    if (is_restart) begin
      restart = 1'b1;
    end else begin
      sync_det = 1'b1;
    end
    @(negedge clk);
    sync_det = 1'b0;
    restart = 1'b0;
    @(negedge clk);
  endtask
  task automatic t_reset();
    rd(6'h1A, 8'h6C);
    rd(6'h1B, 8'h03);
    chk(cfg.int_gain, 4'h4);
    chk(cfg.prop_gain, 4'h6);
    chk(cfg.vga_max_step, 3'h7);
    chk(cfg.amp_target_db, 6'h21);
    $display("test reset done");
  endtask
  // every ceiling and target code
  task automatic t_agc();
    logic [7:0] lna [8] = '{8'h00, 8'h1A, 8'h3D, 8'h4A, 8'h5C, 8'h73, 8'h92, 8'hAB};
    logic [5:0] tgt [8] = '{6'h18, 6'h1B, 6'h1E, 6'h21, 6'h24, 6'h26, 6'h28, 6'h2A};
    for (int i = 0; i < 8; i++) begin
      u_host.wr_reg(6'h1B, {i[1:0], i[2:0], 3'(7 - i)});
      settle();
      chk(cfg.vga_max_step, 3'(7 - i[1:0]));
      chk(cfg.lna_cap_below_max, lna[i]);
      chk(cfg.amp_target_db, tgt[7 - i]);
    end
    $display("test agc done");
  endtask
  // gains before and after sync, limit codes
  task automatic t_gain();
    logic [15:0] lim [4] = '{16'h0000, 16'h0C35, 16'h186A, 16'h30D4};
    logic [3:0] pi;
    logic [3:0] pp;
    for (int k = 0; k < 8; k++) begin
      pi = 4'((k % 4 + 1) * 2);
      pp = 4'((4 - k % 4) * 2);
      u_host.wr_reg(6'h1A, {k[1:0], ~k[1:0], k[2], ~k[2], k[1:0]});
      settle();
      chk(cfg.int_gain, pi);
      chk(cfg.prop_gain, pp);
      chk(cfg.rate_offset_limit, lim[k % 4]);
      pulse(1'b0);
      chk(cfg.int_gain, k[2] ? pi >> 1 : pi);
      chk(cfg.prop_gain, k[2] ? pp : 4'h2);
      pulse(1'b1);
      chk(cfg.int_gain, pi);
    end
    $display("test gain done");
  endtask
  // freeze holds until first carrier, rearms on restart
  task automatic t_freeze();
    loop_freeze_until_carrier = 1'b1;
    settle();
    chk(cfg.loops_frozen, 1'b1);
    carrier = 1'b1;
    settle();
    chk(cfg.loops_frozen, 1'b0);
    carrier = 1'b0;
    settle();
    chk(cfg.loops_frozen, 1'b0);
    pulse(1'b1);
    @(negedge clk);
    chk(cfg.loops_frozen, 1'b1);
    loop_freeze_until_carrier = 1'b0;
    $display("test freeze done");
  endtask
  // write to an unmapped place leaves both registers alone
  task automatic t_unmapped();
    u_host.wr_reg(6'h1C, 8'hFF);
    settle();
    rd(6'h1A, 8'hCB);
    rd(6'h1B, 8'hF8);
    rd(6'h1C, 8'h00);
    $display("test unmapped done");
  endtask
  // detect and restart in one cycle: detect wins; config is 0xCB here (pre code 3, post halve)
  task automatic t_race();
    sync_det = 1'b1;
    restart = 1'b1;
    @(negedge clk);
    sync_det = 1'b0;
    restart = 1'b0;
    @(negedge clk);
    chk(cfg.int_gain, 4'h4);
    pulse(1'b1);
    chk(cfg.int_gain, 4'h8);
    $display("test race done");
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // whole run is under 150 cycles
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    final_report();
  end
  initial begin
    repeat (20) @(negedge clk);
    srst = 1'b0;
    t_reset();
    t_agc();
    t_gain();
    t_freeze();
    t_unmapped();
    t_race();
    final_report();
  end
endmodule // rx_clock_recovery_agc_config_bench
